// [core/dmb_pkg.sv]
// Shared constants, register map and types of the bus-master cycle sequencer.
package dmb_pkg;

	//////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the Wishbone slave port.
	localparam logic [7:0] OFF_CFG   = 8'h00;	// Mode and wait configuration.
	localparam logic [7:0] OFF_STAT  = 8'h04;	// Retry flag and busy state.
	localparam logic [7:0] OFF_ADDR  = 8'h08;	// Memory address, bits 31..1.
	localparam logic [7:0] OFF_WDATA = 8'h0C;	// Write data word.
	localparam logic [7:0] OFF_CMD   = 8'h10;	// Direction and status code; starts a cycle.
	localparam logic [7:0] OFF_RDATA = 8'h14;	// Last captured read data.

	//////////////////////////////////////////////////////////////////////////////
	// Field positions inside the registers.
	localparam int CFG_SYNC_BIT    = 0;	// Synchronous termination select.
	localparam int CFG_WAIT_LSB    = 1;	// Two wait count bits.
	localparam int CFG_LRETRY_BIT  = 3;	// Latched retry enable.
	localparam int CFG_RSAMP_BIT   = 4;	// Asynchronous retry sampling select.
	localparam int STAT_RFLAG_BIT  = 0;	// Retry status flag, write one to clear.
	localparam int STAT_BUSY_BIT   = 1;	// A memory cycle is pending or running.
	localparam int CMD_WRITE_BIT   = 0;	// One for a write cycle.
	localparam int CMD_CODE_LSB    = 1;	// Three-bit bus status code.

	//////////////////////////////////////////////////////////////////////////////
	// Reset values and fixed codes.
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;	// Every register word.
	localparam logic [2:0]  CODE_IDLE = 3'h7;		// Status code shown while idle.

	// Configuration bits as the sequencer sees them.
	typedef struct packed {
		logic       retry_sampling_select;
		logic       latched_retry_enable;
		logic [1:0] wait_count_bits;
		logic       sync_bus_select;
	} dmb_cfg_t;

	// One memory request as latched at the start of a cycle.
	typedef struct packed {
		logic        write;
		logic [2:0]  code;
		logic [31:1] addr;
		logic [31:0] wdata;
	} dmb_req_t;

	// Bus states; T1, each TW, each T2 and TH last one bus clock of two system clocks.
	typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_T1, ST_TW, ST_T2, ST_TH, ST_HOLD} dmb_st_t;

	// Whole state of the sequencer.
	typedef struct packed {
		dmb_st_t     st;
		logic        ph;
		logic [1:0]  wleft;
		logic        ack_seen;
		logic        fin;
		logic        rty;
		logic        rty_set;
		logic        s1;
		logic        s2;
		logic        act;
		logic        breq;
		logic        gack_n;
		logic        gack_oe;
		logic        ecs_n;
		logic        as_n;
		logic        ads_n;
		logic        ds_n;
		logic        d_oe;
		dmb_req_t    req;
		logic [31:0] rdata;
	} dmb_mst_t;

	// Merge a written word into an old one under Wishbone byte selects.
	function automatic logic [31:0] byte_merge(logic [31:0] old, logic [31:0] nw,
		logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

// [core/dmb_regs.sv]
// Wishbone register slave of the bus-master cycle sequencer.
`timescale 1ns/100ps
module dmb_regs
	import dmb_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Sequencer side.
	input  wire logic        busy_i,
	input  wire logic        retry_set_i,
	input  wire logic [31:0] rdata_i,
	output dmb_cfg_t         cfg_o,
	output dmb_req_t         req_o,
	output logic             start_o,
	output logic             retry_flag_o
);

	// Register state as one packed word.
	typedef struct packed {
		dmb_cfg_t    cfg;
		dmb_req_t    req;
		logic [31:0] dat;
		logic        ack;
		logic        start;
		logic        rflag;
	} dmb_rg_t;

	dmb_rg_t q_reg;		// Current register state.
	dmb_rg_t q_next;	// Next register state.
	logic    wr;		// A write takes effect at this edge.
	logic [31:0] cfgw;	// Configuration as a word.
	logic [31:0] cmdw;	// Command as a word.
	logic [31:0] adw;	// Address as a word, bit 0 zero until a write is merged in.

	//////////////////////////////////////////////////////////////////////////////
	// Decode, read mux and register updates.
	always_comb begin
		q_next = q_reg;
		q_next.start = 1'b0;
		cfgw = {27'h0, q_reg.cfg};
		cmdw = {28'h0, q_reg.req.code, q_reg.req.write};
		adw = {q_reg.req.addr, 1'b0};
		// Ack follows one cycle after the request and drops right after.
		q_next.ack = wb_cyc_i & wb_stb_i & ~q_reg.ack;
		wr = wb_cyc_i & wb_stb_i & wb_we_i & q_reg.ack;
		// Read data is prepared while the request waits for its ack.
		if (wb_adr_i == OFF_CFG) begin
			q_next.dat = cfgw;
		end else if (wb_adr_i == OFF_STAT) begin
			q_next.dat = RST_WORD;
			q_next.dat[STAT_RFLAG_BIT] = q_reg.rflag;
			q_next.dat[STAT_BUSY_BIT] = busy_i;
		end else if (wb_adr_i == OFF_ADDR) begin
			q_next.dat = {q_reg.req.addr, 1'b0};
		end else if (wb_adr_i == OFF_WDATA) begin
			q_next.dat = q_reg.req.wdata;
		end else if (wb_adr_i == OFF_CMD) begin
			q_next.dat = cmdw;
		end else if (wb_adr_i == OFF_RDATA) begin
			q_next.dat = rdata_i;
		end else begin
			// Unmapped addresses read as zero and ignore writes.
			q_next.dat = RST_WORD;
		end
		// Writes land at the edge that carries the ack.
		if (wr && wb_adr_i == OFF_CFG) begin
			cfgw = byte_merge(cfgw, wb_dat_i, wb_sel_i);
			q_next.cfg.sync_bus_select = cfgw[CFG_SYNC_BIT];
			q_next.cfg.wait_count_bits = cfgw[CFG_WAIT_LSB +: 2];
			q_next.cfg.latched_retry_enable = cfgw[CFG_LRETRY_BIT];
			q_next.cfg.retry_sampling_select = cfgw[CFG_RSAMP_BIT];
		end else if (wr && wb_adr_i == OFF_ADDR && !busy_i) begin
			// Bit 0 of the merged word is dropped on purpose: addresses are halfword aligned.
			adw = byte_merge(adw, wb_dat_i, wb_sel_i);
			q_next.req.addr = adw[31:1];
		end else if (wr && wb_adr_i == OFF_WDATA && !busy_i) begin
			q_next.req.wdata = byte_merge(q_reg.req.wdata, wb_dat_i, wb_sel_i);
		end else if (wr && wb_adr_i == OFF_CMD && !busy_i) begin
			cmdw = byte_merge(cmdw, wb_dat_i, wb_sel_i);
			q_next.req.write = cmdw[CMD_WRITE_BIT];
			q_next.req.code = cmdw[CMD_CODE_LSB +: 3];
			q_next.start = 1'b1;
		end
		// A retry event wins over a clear in the same cycle.
		if (wr && wb_adr_i == OFF_STAT && wb_sel_i[0] && wb_dat_i[STAT_RFLAG_BIT]) begin
			q_next.rflag = 1'b0;
		end
		if (retry_set_i) begin
			q_next.rflag = 1'b1;
		end
	end

	// Register the state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign wb_dat_o = q_reg.dat;
	assign wb_ack_o = q_reg.ack;
	assign cfg_o = q_reg.cfg;
	assign req_o = q_reg.req;
	assign start_o = q_reg.start;
	assign retry_flag_o = q_reg.rflag;

endmodule

// [core/dmb_master.sv]
// Bus-master memory cycle sequencer for buffer DMA, top level.
// Function
// - Drive strobe, address, code, direction for cycle
// - Big-endian: mid T1 swap early for address strobe
// - Big sync: sample ack pair each T2 start
// - Big read: data strobe mid T1, capture final
// - Writes drive data from mid T1
// - Waited writes strobe in first wait, except little sync; zero-wait none
// - Big-endian: release strobes mid final T2
// - Big async: sample ack mid T1/T2 internally
// - Big async: terminate input at T2 start too
// - Async end 1.5 after ack, 1 after terminate
// - Little-endian: valid strobe T1 start to T1 end
// - Little sync: ready sampled at T2 end
// - Little sync: capture at T2 end, data held
// - Little async: ready sampled mid T1/T2
// - Little async: data strobe timing per direction
// - Retry ends cycle, releases bus, grant ack high
// - Unlatched retry: request bus, repeat same cycle
// - Latched retry: wait flag clear and input high
// - Retry outranks ack, terminate and ready
// - Retry sampled at T2 start or synchronised
// - Style pin high big-endian, low little-endian
// - Configuration bit picks sync or async termination
// - Insert programmed wait states after T1
// - Ignore termination inputs during all but the last programmed wait
`timescale 1ns/100ps
module dmb_master
	import dmb_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Bus style strap and derived bus clock.
	input  wire logic        bus_style_select_i,
	output logic             bus_clk_o,
	// Bus ownership.
	output logic             bus_request_o,
	input  wire logic        bus_grant_i,
	output logic             grant_acknowledge_n_o,
	output logic             grant_acknowledge_n_oe_o,
	// Cycle strobes and address phase.
	output logic             early_cycle_strobe_n_o,
	output logic             address_strobe_n_o,
	output logic             address_valid_strobe_n_o,
	output logic             data_strobe_n_o,
	output logic             read_write_direction_o,
	output logic             write_read_direction_o,
	output logic      [2:0]  bus_status_code_o,
	output logic      [31:1] addr_o,
	// Data bus.
	output logic      [31:0] data_o,
	output logic             data_oe_o,
	input  wire logic [31:0] data_i,
	// Termination and exception inputs, active low.
	input  wire logic [1:0]  size_ack_pair_n_i,
	input  wire logic        sync_terminate_n_i,
	input  wire logic        ready_input_n_i,
	input  wire logic        retry_request_n_i
);

	//////////////////////////////////////////////////////////////////////////////
	// Register slave.

	dmb_cfg_t cfg;		// Live configuration.
	dmb_req_t req;		// Request fields set up by software.
	logic     start;	// Pulse: software started a cycle.
	logic     rflag;	// Retry status flag.
	dmb_mst_t q_reg;	// Current sequencer state.
	dmb_mst_t q_next;	// Next sequencer state.

	dmb_regs u_regs (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.wb_cyc_i     (wb_cyc_i),
		.wb_stb_i     (wb_stb_i),
		.wb_we_i      (wb_we_i),
		.wb_adr_i     (wb_adr_i),
		.wb_sel_i     (wb_sel_i),
		.wb_dat_i     (wb_dat_i),
		.wb_dat_o     (wb_dat_o),
		.wb_ack_o     (wb_ack_o),
		.busy_i       (q_reg.st != ST_IDLE),
		.retry_set_i  (q_reg.rty_set),
		.rdata_i      (q_reg.rdata),
		.cfg_o        (cfg),
		.req_o        (req),
		.start_o      (start),
		.retry_flag_o (rflag)
	);

	//////////////////////////////////////////////////////////////////////////////
	// Decoded modes and input conditions.

	logic bs;	// Big-endian style selected.
	logic syn;	// Synchronous termination selected.
	logic lsync;	// Little-endian synchronous mode.
	logic ack_low;	// Both size acknowledges low.
	logic pre_t2;	// Current state is the one before a T2, or a T2.
	logic enter;	// This edge starts a T2.
	logic mid_samp;	// This edge is an asynchronous mid-state sample.
	logic rty_now;	// Retry sampled at the start of this T2.
	logic rty_async;	// Synchronised retry seen inside the cycle.

	assign bs = bus_style_select_i;
	assign syn = cfg.sync_bus_select;
	assign lsync = !bs && syn;
	assign ack_low = (size_ack_pair_n_i == 2'b00);

	//////////////////////////////////////////////////////////////////////////////
	// Sequencer: phase 0 is the first half of a bus state, phase 1 the second.
	always_comb begin
		q_next = q_reg;
		q_next.ph = ~q_reg.ph;
		q_next.rty_set = 1'b0;
		// Two-stage retry synchroniser; only the second stage is looked at.
		q_next.s1 = retry_request_n_i;
		q_next.s2 = q_reg.s1;
		// Termination inputs count only from the last programmed wait on.
		pre_t2 = (q_reg.st == ST_T1 && q_reg.wleft == 2'h0) ||
			(q_reg.st == ST_TW && q_reg.wleft == 2'h1) || q_reg.st == ST_T2;
		enter = q_reg.ph && pre_t2 &&
			!(q_reg.st == ST_T2 && (q_reg.fin || lsync));
		mid_samp = !q_reg.ph && pre_t2 && !syn;
		rty_now = !cfg.retry_sampling_select && !retry_request_n_i;
		rty_async = cfg.retry_sampling_select && !q_reg.s2 &&
			((q_reg.st == ST_T1 && q_reg.ph) || q_reg.st == ST_TW ||
			q_reg.st == ST_T2);
		case (q_reg.st)
			ST_IDLE: begin
				// Latch the request so it stays put for the whole cycle.
				if (start) begin
					q_next.req = req;
					q_next.breq = 1'b1;
					q_next.st = ST_REQ;
				end
			end
			ST_REQ: begin
				// Take the bus on a state boundary once granted.
				if (q_reg.ph && bus_grant_i) begin
					q_next.st = ST_T1;
					q_next.act = 1'b1;
					q_next.ecs_n = 1'b0;
					q_next.ads_n = bs;
					q_next.ds_n = bs || syn || q_reg.req.write;
					q_next.gack_n = 1'b0;
					q_next.gack_oe = 1'b1;
					q_next.wleft = cfg.wait_count_bits;
					q_next.ack_seen = 1'b0;
					q_next.fin = 1'b0;
					q_next.rty = 1'b0;
				end
			end
			ST_T1: begin
				if (!q_reg.ph) begin
					// Middle of T1.
					q_next.ecs_n = 1'b1;
					if (bs) begin
						q_next.as_n = 1'b0;
						q_next.ds_n = q_reg.req.write;
					end
					q_next.d_oe = q_reg.req.write;
				end else begin
					// Start of the next state ends the address-valid strobe.
					q_next.ads_n = 1'b1;
					if (q_reg.wleft != 2'h0) begin
						q_next.st = ST_TW;
						if (!bs && !syn && q_reg.req.write) begin
							q_next.ds_n = 1'b0;
						end
					end
				end
			end
			ST_TW: begin
				if (!q_reg.ph) begin
					// Big-endian waited write strobes in the first wait.
					if (bs && q_reg.req.write && q_reg.wleft == cfg.wait_count_bits) begin
						q_next.ds_n = 1'b0;
					end
				end else begin
					q_next.wleft = q_reg.wleft - 2'h1;
				end
			end
			ST_T2: begin
				if (!q_reg.ph) begin
					// Middle of a final T2 releases the strobes.
					if (q_reg.fin) begin
						q_next.as_n = 1'b1;
						q_next.ds_n = 1'b1;
						if (!q_reg.req.write && !q_reg.rty && !lsync) begin
							q_next.rdata = data_i;
						end
					end
				end else if (q_reg.fin || (lsync && (q_reg.rty || !ready_input_n_i))) begin
					// End of the final T2: free the bus.
					q_next.st = ST_TH;
					q_next.act = 1'b0;
					q_next.as_n = 1'b1;
					q_next.ds_n = 1'b1;
					q_next.d_oe = 1'b0;
					q_next.gack_n = 1'b1;
					q_next.rty_set = q_reg.rty || rty_async;
					if (lsync && !q_reg.rty && !q_reg.req.write) begin
						q_next.rdata = data_i;
					end
				end
			end
			ST_TH: begin
				if (!q_reg.ph) begin
					// Grant acknowledge was high for half a bus clock; float it.
					q_next.gack_oe = 1'b0;
					q_next.breq = 1'b0;
				end else if (!q_reg.rty) begin
					q_next.st = ST_IDLE;
				end else if (cfg.latched_retry_enable) begin
					q_next.st = ST_HOLD;
				end else begin
					q_next.st = ST_REQ;
					q_next.breq = 1'b1;
				end
			end
			ST_HOLD: begin
				// Repeat only after software cleared the flag and retry went away.
				if (!rflag && retry_request_n_i) begin
					q_next.st = ST_REQ;
					q_next.breq = 1'b1;
				end
			end
			default: begin
				q_next.st = ST_IDLE;
			end
		endcase
		// Asynchronous modes sample the acknowledge at mid-state.
		if (mid_samp) begin
			q_next.ack_seen = q_reg.ack_seen | (bs ? ack_low : !ready_input_n_i);
		end
		if (rty_async) begin
			q_next.rty = 1'b1;
		end
		// Entering a T2 decides whether it is the last one.
		if (enter) begin
			q_next.st = ST_T2;
			q_next.rty = q_reg.rty | rty_now;
			if (bs && syn) begin
				q_next.fin = ack_low;
			end else if (bs) begin
				q_next.fin = q_reg.ack_seen | !sync_terminate_n_i;
			end else begin
				q_next.fin = q_reg.ack_seen;
			end
			if (q_reg.rty || rty_now || rty_async) begin
				q_next.fin = 1'b1;
				q_next.rty = 1'b1;
			end
		end
	end

	// Register the sequencer state; strobes idle high.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_reg <= '{st: ST_IDLE, ph: 1'b0, wleft: 2'h0, ack_seen: 1'b0,
				fin: 1'b0, rty: 1'b0, rty_set: 1'b0, s1: 1'b1, s2: 1'b1,
				act: 1'b0, breq: 1'b0, gack_n: 1'b1, gack_oe: 1'b0,
				ecs_n: 1'b1, as_n: 1'b1, ads_n: 1'b1, ds_n: 1'b1,
				d_oe: 1'b0, req: '0, rdata: RST_WORD};
		end else begin
			q_reg <= q_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Pin outputs.

	assign bus_clk_o = ~q_reg.ph;
	assign bus_request_o = q_reg.breq;
	assign grant_acknowledge_n_o = q_reg.gack_n;
	assign grant_acknowledge_n_oe_o = q_reg.gack_oe;
	assign early_cycle_strobe_n_o = q_reg.ecs_n;
	assign address_strobe_n_o = q_reg.as_n;
	assign address_valid_strobe_n_o = q_reg.ads_n;
	assign data_strobe_n_o = q_reg.ds_n;
	assign read_write_direction_o = !(q_reg.act && q_reg.req.write);
	assign write_read_direction_o = q_reg.act && q_reg.req.write;
	assign bus_status_code_o = q_reg.act ? q_reg.req.code : CODE_IDLE;
	assign addr_o = q_reg.req.addr;
	assign data_o = q_reg.req.wdata;
	assign data_oe_o = q_reg.d_oe;

	//////////////////////////////////////////////////////////////////////////////
	// Checks on the sequencer.

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// The early strobe lasts exactly one half of T1.
	sequence s_ecs_pulse;
		!early_cycle_strobe_n_o ##1 early_cycle_strobe_n_o;
	endsequence

	// Entering T1 leads to T1 in its first half, then its second, lasting two clocks.
	sequence s_t1_span;
		(q_reg.st == ST_T1 && !q_reg.ph) ##1 (q_reg.st == ST_T1 && q_reg.ph);
	endsequence
	// Second half of a final T2, then the bus-release state.
	sequence s_final_t2;
		(q_reg.st == ST_T2 && q_reg.ph && q_reg.fin) ##1 (q_reg.st == ST_TH);
	endsequence

	a_ecs_half_cycle: assert property ($fell(early_cycle_strobe_n_o) |-> s_ecs_pulse)
		else $error("early strobe not one half state");
	a_t1_one_clock: assert property ($rose(q_reg.st == ST_T1) |-> s_t1_span ##1
		(q_reg.st != ST_T1))
		else $error("T1 not one bus clock");
	a_addr_held: assert property (q_reg.act && $past(q_reg.act) |->
		$stable(addr_o) && $stable(bus_status_code_o))
		else $error("address moved during cycle");
	a_big_as_mid: assert property ((q_reg.st == ST_T1 && !q_reg.ph && bs) |=>
		!address_strobe_n_o && early_cycle_strobe_n_o)
		else $error("address strobe late");
	a_little_ads: assert property ($fell(address_valid_strobe_n_o) |->
		!early_cycle_strobe_n_o ##2 address_valid_strobe_n_o)
		else $error("valid strobe width wrong");
	a_wait_insert: assert property ((q_reg.st == ST_T1 && q_reg.ph &&
		q_reg.wleft != 2'h0) |=> q_reg.st == ST_TW)
		else $error("wait state skipped");
	a_wait_ignore: assert property ((q_reg.st == ST_TW && q_reg.wleft > 2'h1) |->
		!q_reg.ack_seen && !q_reg.fin)
		else $error("acknowledge taken during wait");
	a_zero_wait_write: assert property ((q_reg.act && q_reg.req.write &&
		q_reg.st == ST_T1) |-> data_strobe_n_o)
		else $error("write strobe in T1");
	a_sync_repeat: assert property ((q_reg.st == ST_T2 && q_reg.ph && !q_reg.fin &&
		!lsync) |=> q_reg.st == ST_T2)
		else $error("T2 not repeated");
	a_retry_end: assert property ((q_reg.st == ST_T2 && q_reg.ph && q_reg.fin &&
		q_reg.rty) |=> q_reg.rty_set && q_reg.st == ST_TH ##1 !grant_acknowledge_n_oe_o)
		else $error("retry end wrong");
	a_retry_again: assert property ((q_reg.st == ST_TH && q_reg.ph && q_reg.rty &&
		!cfg.latched_retry_enable) |=> q_reg.st == ST_REQ && bus_request_o)
		else $error("retry not repeated");
	a_latched_hold: assert property ((q_reg.st == ST_HOLD && rflag) |=>
		q_reg.st == ST_HOLD)
		else $error("latched retry left early");
	a_retry_first: assert property ((enter && rty_now) |=> q_reg.fin && q_reg.rty)
		else $error("retry lost priority");
	a_strobe_release: assert property ((q_reg.st == ST_T2 && !q_reg.ph && q_reg.fin) |=>
		address_strobe_n_o && data_strobe_n_o)
		else $error("strobes held past final T2");
	a_async_finish: assert property ((mid_samp && !q_reg.ack_seen && !q_reg.fin &&
		(bs ? ack_low : !ready_input_n_i)) |-> ##3 s_final_t2)
		else $error("asynchronous end not one and a half bus clocks after sample");

endmodule

// [tb/dmb_mem_model.sv]
// Memory bus partner: grant, termination and memory data.
`timescale 1ns/100ps
module dmb_mem_model (
	// Clock and bench controls.
	input  wire logic        clk_i,
	input  wire logic [3:0]  lat_i,
	input  wire logic        term_i,
	// Bus style strap and sequencer outputs.
	input  wire logic        style_i,
	input  wire logic        req_i,
	input  wire logic        gack_n_i,
	input  wire logic        ecs_n_i,
	input  wire logic        rd_i,
	input  wire logic        doe_i,
	input  wire logic [2:0]  code_i,
	input  wire logic [31:1] addr_i,
	input  wire logic [31:0] wd_i,
	// Answers and write record.
	output logic             grant_o = 1'b0,
	output logic      [31:0] data_o = 32'h0,
	output logic      [1:0]  ack_n_o,
	output logic             term_n_o,
	output logic             rdy_n_o,
	output logic             wr_v_o = 1'b0,
	output logic      [65:0] wr_o = '0
);
	logic       in_cyc = 1'b0;	// A cycle is open.
	logic [3:0] cnt    = 4'h0;	// Clocks since T1.
	logic       doe_q  = 1'b0;	// Data enable delayed.
	logic       hit;		// Termination due.

	// Never terminate inside T1, since lat_i is at least two.
	assign hit      = in_cyc && (cnt >= lat_i);
	assign ack_n_o  = {2{!(hit && style_i && !term_i)}};
	assign term_n_o = !(hit && style_i && term_i);
	assign rdy_n_o  = !(hit && !style_i);

	// Grant, cycle tracking, read word and write capture.
	always @(posedge clk_i) begin
		grant_o <= req_i;
		doe_q   <= doe_i;
		wr_v_o  <= doe_q && !doe_i;
		// Released data lines toggle rather than hold.
		data_o  <= (in_cyc && rd_i) ? ({addr_i, 1'b1} ^ {29'h0, code_i}) : ~data_o;
		if (doe_i) begin
			wr_o <= {code_i, addr_i, wd_i};
		end
		if (!ecs_n_i) begin
			in_cyc <= 1'b1;
			cnt    <= 4'h0;
		end else if (gack_n_i) begin
			in_cyc <= 1'b0;
		end else if (cnt != 4'hF) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

// [tb/tb_dmb_master.sv]
// Self-checking bench for the bus-master cycle sequencer.
`timescale 1ns/100ps
module tb_dmb_master
	import dmb_pkg::*;
;
	// Bench signals, all inputs valued at time zero.
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, chk = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hF, lat = 4'h2;
	logic [31:0] dat = 32'h0, wq_d, qd, last_rd = 32'h0, dout, din;
	logic        ack, style = 1'b0, term = 1'b0, rty_n = 1'b1, breq, grant;
	logic        gack_n, gack_oe, ecs_n, rdn, doe, wr_v, term_n, rdy_n;
	logic [1:0]  ack_n;
	logic [2:0]  code;
	logic [31:1] addr;
	logic [65:0] wr;
	logic [31:0] rq[$];	// Expected register reads.
	logic [65:0] wq[$];	// Expected write records.
	int          n_errors = 0, n_tests = 0;

	always #2.5 clk_i = ~clk_i;

	dmb_master dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wq_d), .wb_ack_o(ack),
		.bus_style_select_i(style), .bus_clk_o(), .bus_request_o(breq), .bus_grant_i(grant),
		.grant_acknowledge_n_o(gack_n), .grant_acknowledge_n_oe_o(gack_oe),
		.early_cycle_strobe_n_o(ecs_n), .address_strobe_n_o(), .address_valid_strobe_n_o(),
		.data_strobe_n_o(), .read_write_direction_o(rdn), .write_read_direction_o(),
		.bus_status_code_o(code), .addr_o(addr), .data_o(dout), .data_oe_o(doe), .data_i(din),
		.size_ack_pair_n_i(ack_n), .sync_terminate_n_i(term_n), .ready_input_n_i(rdy_n),
		.retry_request_n_i(rty_n));
	dmb_mem_model mem (.clk_i, .lat_i(lat), .term_i(term), .style_i(style), .req_i(breq),
		.gack_n_i(gack_n), .ecs_n_i(ecs_n), .rd_i(rdn), .doe_i(doe), .code_i(code),
		.addr_i(addr), .wd_i(dout), .grant_o(grant), .data_o(din), .ack_n_o(ack_n),
		.term_n_o(term_n), .rdy_n_o(rdy_n), .wr_v_o(wr_v), .wr_o(wr));

	// Prints the counts and the verdict, then stops.
	task automatic close_out();
		$display("errors=%0d tests=%0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Shared comparison with report.
	task automatic cmp(input logic [65:0] g, input logic [65:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmp_rd(input logic [31:0] g);
		cmp({34'h0, g}, {34'h0, rq.pop_front()});
	endtask
	task automatic cmp_wr(input logic [65:0] g);
		cmp(g, wq.pop_front());
	endtask

	// Watches results and takes the oldest note for each.
	always @(posedge clk_i) begin
		if (ack === 1'b1 && chk && !we) cmp_rd(wq_d);
		if (wr_v === 1'b1) cmp_wr(wr);
	end

	// One classic Wishbone cycle, held until ack is sampled.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic c, output logic [31:0] q);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		chk <= c;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = wq_d;
		if (k >= 50) n_errors++;
		cyc <= 1'b0;
		chk <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		wb(1'b0, a, 32'h0, 4'hF, 1'b1, qd);
	endtask
	// Polls the busy flag, bounded.
	task automatic poll();
		int k;
		k = 0;
		qd = 32'h2;
		while (qd[STAT_BUSY_BIT] !== 1'b0 && k < 200) begin
			wb(1'b0, OFF_STAT, 32'h0, 4'hF, 1'b0, qd);
			k++;
		end
		if (k >= 200) n_errors++;
	endtask
	task automatic wait_oe(input logic v);
		int k;
		k = 0;
		while (gack_oe !== v && k < 100) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 100) n_errors++;
	endtask

	// One memory cycle; the data word is written in two byte-lane halves.
	task automatic mcyc(input logic w, input logic [4:0] cfg, input logic rty);
		logic [31:0] a, d, e;
		logic [2:0]  c;
		a = $urandom;
		d = $urandom;
		c = 3'($urandom);
		e = {a[31:1], 1'b1} ^ {29'h0, c};
		lat <= 4'h2 + 4'($urandom % 7);
		wb(1'b1, OFF_CFG, {27'h0, cfg}, 4'hF, 1'b0, qd);
		wb(1'b1, OFF_ADDR, a, 4'hF, 1'b0, qd);
		wb(1'b1, OFF_WDATA, d, 4'h3, 1'b0, qd);
		wb(1'b1, OFF_WDATA, ~d, 4'hC, 1'b0, qd);
		if (w) wq.push_back({c, a[31:1], ~d[31:16], d[15:0]});
		rty_n <= !rty;
		wb(1'b1, OFF_CMD, {28'h0, c, w}, 4'hF, 1'b0, qd);
		if (rty) begin
			wait_oe(1'b1);
			wait_oe(1'b0);
			rty_n <= 1'b1;
			if (cfg[CFG_LRETRY_BIT]) begin
				repeat (20) @(posedge clk_i);
				rd(OFF_STAT, 32'h3);
				rd(OFF_RDATA, last_rd);
				wb(1'b1, OFF_STAT, 32'h1, 4'hF, 1'b0, qd);
			end
		end
		poll();
		if (rty && !cfg[CFG_LRETRY_BIT]) begin
			rd(OFF_STAT, 32'h1);
			wb(1'b1, OFF_STAT, 32'h1, 4'hF, 1'b0, qd);
		end
		if (!w) begin
			rd(OFF_RDATA, e);
			last_rd = e;
		end
	endtask

	// Reset values, every style, mode, wait count and direction, then retries.
	initial begin
		static logic [7:0] offs[6] = '{OFF_CFG, OFF_STAT, OFF_ADDR, OFF_WDATA, OFF_RDATA, 8'h1C};
		void'($urandom(32'h2978f2e5));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (offs[i]) rd(offs[i], RST_WORD);
		for (int m = 0; m < 32; m++) begin
			if (m == 16) begin
				style <= 1'b1;
				rst_i <= 1'b1;
				repeat (3) @(posedge clk_i);
				rst_i <= 1'b0;
				last_rd = RST_WORD;
			end
			term <= m[4] && !m[3] && m[1];
			mcyc(m[0], {2'b00, m[2:1], m[3]}, 1'b0);
		end
		term <= 1'b0;
		mcyc(1'b0, 5'h03, 1'b1);
		mcyc(1'b0, 5'h18, 1'b1);
		close_out();
	end

	// Cuts a hang short.
	initial begin
		#200000;
		n_errors++;
		close_out();
	end
endmodule
